// file: rtl/pfc_port_pin_ctrl.sv
`timescale 1ns/100ps
// port pin and shared function control with apb register access
module pfc_port_pin_ctrl
  import pfc_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire pfc_apb_req_type apbReq,
  output pfc_apb_rsp_type      apbRsp,
  input  wire logic [23:0]     padIn,
  output pfc_pad_type          padDrv,
  input  wire logic [3:0]      lowThreshIn,
  output logic                 lowThreshPullEn,
  input  wire logic [2:0]      serSckOut,
  input  wire logic [2:0]      serSckDrive,
  input  wire logic [2:0]      serDataOut,
  output logic      [2:0]      serSckIn,
  output logic      [2:0]      serDataIn,
  output logic      [1:0]      extIrqPin,
  input  wire logic            pllDivHigh,
  input  wire logic            pllDivLow,
  input  wire logic            pll2DivHigh,
  input  wire logic            pll2DivLow,
  output logic                 mainPumpOutA,
  output logic                 mainPumpOeNA,
  output logic                 mainPumpOutB,
  output logic                 mainPumpOeNB,
  input  wire logic            subPumpIn,
  output logic                 subPumpOut,
  output logic                 subPumpOeN,
  input  wire logic            secondPumpIn,
  output logic                 secondPumpOut,
  output logic                 secondPumpOeN,
  output logic                 fmOscInEn,
  output logic                 amOscInEn,
  output logic                 amBandMwLw,
  output logic                 pllRun,
  output logic                 backupMode
);

  // block state apart from the reset release flops in one record
  typedef struct packed {
    logic [15:0]     cfgOne;
    logic [15:0]     cfgTwo;
    logic [23:0]     outData;
    logic [3:0]      pllCtl;
    logic [1:0]      irqEn;
    pfc_apb_rsp_type rsp;
    pfc_pad_type     pad;
    logic [2:0]      sckIn;
    logic [2:0]      dataIn;
    logic [1:0]      irqPin;
    logic            fmEn;
    logic            amEn;
    logic            amBand;
    logic            pullEn;
  } pfc_state_type;

  // reset record: general-purpose inputs, pads and pumps floating
  localparam pfc_state_type ST_RST = '{
    cfgOne:  PFC_CFG_ONE_RST,
    cfgTwo:  PFC_CFG_TWO_RST,
    outData: PFC_OUT_DATA_RST,
    pllCtl:  PFC_PLL_CTL_RST,
    irqEn:   PFC_IRQ_EN_RST,
    rsp:     '0,
    pad:     '{out: '0, oeN: '1},
    sckIn:   '0,
    dataIn:  '0,
    irqPin:  '0,
    fmEn:    1'b0,
    amEn:    1'b0,
    amBand:  1'b0,
    pullEn:  1'b0
  };

  // reset release, synchronised pins and mode decodes
  logic [1:0]      rstSync_r;
  logic            rstnSync;
  pfc_state_type   st_r;
  pfc_state_type   st_nxt;
  logic [29:0]     syncIn;
  logic [29:0]     syncOut;
  logic [23:0]     padSync;
  logic [3:0]      ltSync;
  logic            subSync;
  logic            secondSync;
  logic            bk;
  logic            pumpEn;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  // the rest of the block resets from this copy
  assign rstnSync = rstSync_r[1];

  // all pin inputs through the synchroniser
  assign syncIn = {secondPumpIn, subPumpIn, lowThreshIn, padIn};

  pfc_pin_sync #(
    .W (PFC_SYNC_W)
  ) u_sync (
    .clk  (ref_clk),
    .rstn (rstnSync),
    .d    (syncIn),
    .q    (syncOut)
  );

  // split the synchronised bundle back into its groups
  assign padSync    = syncOut[23:0];
  assign ltSync     = syncOut[27:24];
  assign subSync    = syncOut[28];
  assign secondSync = syncOut[29];

  // mode decodes from the pll control register
  assign bk     = st_r.pllCtl[PFC_BACKUP_BIT];
  assign pumpEn = st_r.pllCtl[PFC_PLL_RUN_BIT] && !bk;

  // true for any of the six register offsets
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == PFC_CFG_ONE_OFS) || (a == PFC_CFG_TWO_OFS) ||
               (a == PFC_OUT_DATA_OFS) || (a == PFC_PLL_CTL_OFS) ||
               (a == PFC_IRQ_EN_OFS) || (a == PFC_PIN_READ_OFS);
  endfunction

  // pad driver: open drain pulls low only, push-pull drives the value
  function automatic logic [1:0] padDrive(input logic val, input logic en, input logic od);
    if (od) begin
      padDrive = {1'b0, !(en && !val)};
    end else begin
      padDrive = {val, !en};
    end
  endfunction

  // pad bit of a pin within its port
  function automatic int padIdx(input int port, input int pin);
    padIdx = port * PFC_PINS_PER_PORT + pin;
  endfunction

  // next state: bus slave, pad control, shared function routing
  always_comb begin
    int          port;
    int          pin;
    int          ch;
    logic        dir;
    logic        val;
    logic        drive;
    logic        od;
    logic [31:0] rdata;
    // loop scratch, cleared so nothing latches
    port  = 0;
    pin   = 0;
    ch    = 0;
    dir   = 1'b0;
    val   = 1'b0;
    drive = 1'b0;
    od    = 1'b0;
    rdata = 32'h00000000;
    // every register holds unless written
    st_nxt = st_r;

    // read mux
    unique case (apbReq.paddr)
      PFC_CFG_ONE_OFS:  rdata = {16'h0000, st_r.cfgOne};
      PFC_CFG_TWO_OFS:  rdata = {16'h0000, st_r.cfgTwo};
      PFC_OUT_DATA_OFS: rdata = {8'h00, st_r.outData};
      PFC_PLL_CTL_OFS:  rdata = {28'h0000000, st_r.pllCtl};
      PFC_IRQ_EN_OFS:   rdata = {30'h0, st_r.irqEn};
      PFC_PIN_READ_OFS: begin
        if (!bk) begin
          rdata[23:0]  = padSync;
          rdata[27:24] = ltSync;
          rdata[28]    = subSync && !st_r.cfgTwo[PFC_SUB_PUMP_BIT];
          rdata[29]    = secondSync && !st_r.cfgTwo[PFC_SECOND_PMP_BIT];
        end
      end
      default:          rdata = 32'h00000000;
    endcase

    // apb: answer with pready in the first access cycle
    st_nxt.rsp.pready  = 1'b0;
    st_nxt.rsp.pslverr = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      st_nxt.rsp.pready  = 1'b1;
      st_nxt.rsp.prdata  = apbReq.pwrite ? 32'h00000000 : rdata;
      st_nxt.rsp.pslverr = !isMapped(apbReq.paddr);
    end
    // a write lands at the access edge while ready stands
    if (apbReq.psel && apbReq.penable && st_r.rsp.pready && apbReq.pwrite) begin
      unique case (apbReq.paddr)
        PFC_CFG_ONE_OFS:  st_nxt.cfgOne  = apbReq.pwdata[15:0];
        PFC_CFG_TWO_OFS:  st_nxt.cfgTwo  = apbReq.pwdata[15:0];
        PFC_OUT_DATA_OFS: st_nxt.outData = apbReq.pwdata[23:0];
        PFC_PLL_CTL_OFS:  st_nxt.pllCtl  = apbReq.pwdata[3:0];
        PFC_IRQ_EN_OFS:   st_nxt.irqEn   = apbReq.pwdata[1:0];
        default:          st_nxt.cfgOne  = st_r.cfgOne;
      endcase
    end

    // pad drive per pin
    for (int i = 0; i < PFC_PAD_W; i++) begin
      // locate the pin and its serial channel
      port = i / PFC_PINS_PER_PORT;
      pin  = i % PFC_PINS_PER_PORT;
      ch   = port - PFC_PORT_SER0;
      val  = st_r.outData[i];
      od   = 1'b0;
      // direction bit from the owning config register
      if (port == PFC_PORT_B) begin
        dir = st_r.cfgTwo[PFC_DIR_B_LSB + pin];
      end else if (port == PFC_PORT_C) begin
        dir = st_r.cfgTwo[PFC_DIR_C_LSB + pin];
        od  = 1'b1;
      end else if (port == PFC_PORT_D) begin
        dir = st_r.cfgTwo[PFC_DIR_D_LSB + pin];
      end else begin
        dir = st_r.cfgOne[PFC_SER_DIR_LSB + PFC_PINS_PER_PORT * ch + pin];
      end
      drive = dir;
      // serial function takes pins 1 to 3, pin 0 stays general purpose
      if (port >= PFC_PORT_SER0 && st_r.cfgOne[PFC_SER_SEL_LSB + ch]) begin
        unique case (pin)
          1: begin
            val   = serSckOut[ch];
            drive = serSckDrive[ch];
          end
          2: begin
            val   = serDataOut[ch];
            drive = 1'b1;
          end
          3: drive = 1'b0;
          default: drive = dir;
        endcase
      end
      // channel 2 clock and data out may be made open drain
      if (ch == PFC_OD_CH && pin == 1) begin
        od = st_r.cfgTwo[PFC_OD_SCK2_BIT];
      end
      if (ch == PFC_OD_CH && pin == 2) begin
        od = st_r.cfgTwo[PFC_OD_SO2_BIT];
      end
      // backup mode floats every pad
      {st_nxt.pad.out[i], st_nxt.pad.oeN[i]} = padDrive(val, drive && !bk, od);
    end

    // serial inputs back to the channels, zero in backup
    for (int k = 0; k < PFC_SER_CH; k++) begin
      st_nxt.sckIn[k]  = padSync[padIdx(PFC_PORT_SER0 + k, 1)] && !bk;
      st_nxt.dataIn[k] = padSync[padIdx(PFC_PORT_SER0 + k, 3)] && !bk;
    end

    // external interrupt pins gated by their enables
    // software turns the pin to input first; backup reads low
    for (int k = 0; k < PFC_IRQ_EN_W; k++) begin
      st_nxt.irqPin[k] = st_r.irqEn[k] && !bk &&
                         padSync[padIdx(PFC_PORT_D, k)];
    end

    // oscillator input selection
    st_nxt.fmEn   = pumpEn && !st_r.pllCtl[PFC_CW1_LSB + 1];
    st_nxt.amEn   = pumpEn && st_r.pllCtl[PFC_CW1_LSB + 1];
    st_nxt.amBand = st_r.pllCtl[PFC_CW1_LSB];

    // one pull-down enable shared by all four low-threshold pins
    st_nxt.pullEn = st_r.cfgOne[PFC_PULL_EN_BIT];
  end

  // state register, reset gives all-input general purpose pins
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // charge pump drivers
  pfc_pump_drive u_pump_a (
    .clk     (ref_clk),
    .rstn    (rstnSync),
    .enable  (pumpEn),
    .divHigh (pllDivHigh),
    .divLow  (pllDivLow),
    .invert  (1'b0),
    .pumpOut (mainPumpOutA),
    .pumpOeN (mainPumpOeNA)
  );

  // second main pump pin, same comparator and enable
  pfc_pump_drive u_pump_b (
    .clk     (ref_clk),
    .rstn    (rstnSync),
    .enable  (pumpEn),
    .divHigh (pllDivHigh),
    .divLow  (pllDivLow),
    .invert  (1'b0),
    .pumpOut (mainPumpOutB),
    .pumpOeN (mainPumpOeNB)
  );

  // sub pump shares the main comparator, drives only when selected
  pfc_pump_drive u_pump_sub (
    .clk     (ref_clk),
    .rstn    (rstnSync),
    .enable  (pumpEn && st_r.cfgTwo[PFC_SUB_PUMP_BIT]),
    .divHigh (pllDivHigh),
    .divLow  (pllDivLow),
    .invert  (1'b0),
    .pumpOut (subPumpOut),
    .pumpOeN (subPumpOeN)
  );

  // second pll pump, inverted polarity, drives only when selected
  pfc_pump_drive u_pump_second (
    .clk     (ref_clk),
    .rstn    (rstnSync),
    .enable  (pumpEn && st_r.cfgTwo[PFC_SECOND_PMP_BIT]),
    .divHigh (pll2DivHigh),
    .divLow  (pll2DivLow),
    .invert  (1'b1),
    .pumpOut (secondPumpOut),
    .pumpOeN (secondPumpOeN)
  );

  // outputs straight from the state register
  assign apbRsp          = st_r.rsp;
  assign padDrv          = st_r.pad;
  assign lowThreshPullEn = st_r.pullEn;
  assign serSckIn        = st_r.sckIn;
  assign serDataIn       = st_r.dataIn;
  assign extIrqPin       = st_r.irqPin;
  assign fmOscInEn       = st_r.fmEn;
  assign amOscInEn       = st_r.amEn;
  assign amBandMwLw      = st_r.amBand;
  // pll control bits seen outside
  assign pllRun          = st_r.pllCtl[PFC_PLL_RUN_BIT];
  assign backupMode      = st_r.pllCtl[PFC_BACKUP_BIT];

endmodule // pfc_port_pin_ctrl

// file: rtl/pfc_pkg.sv
package pfc_pkg;

  // register byte offsets
  localparam logic [7:0] PFC_CFG_ONE_OFS  = 8'h00;
  localparam logic [7:0] PFC_CFG_TWO_OFS  = 8'h04;
  localparam logic [7:0] PFC_OUT_DATA_OFS = 8'h08;
  localparam logic [7:0] PFC_PLL_CTL_OFS  = 8'h0c;
  localparam logic [7:0] PFC_IRQ_EN_OFS   = 8'h10;
  localparam logic [7:0] PFC_PIN_READ_OFS = 8'h14;

  // port_config_cmd_one fields
  localparam int PFC_PULL_EN_BIT = 0;
  localparam int PFC_SER_SEL_LSB = 1;
  localparam int PFC_SER_DIR_LSB = 4;
  localparam int PFC_CFG_ONE_W   = 16;
  // port_config_cmd_two fields
  localparam int PFC_DIR_B_LSB      = 0;
  localparam int PFC_DIR_C_LSB      = 4;
  localparam int PFC_DIR_D_LSB      = 8;
  localparam int PFC_OD_SCK2_BIT    = 12;
  localparam int PFC_OD_SO2_BIT     = 13;
  localparam int PFC_SUB_PUMP_BIT   = 14;
  localparam int PFC_SECOND_PMP_BIT = 15;
  localparam int PFC_CFG_TWO_W      = 16;
  // pll control fields
  localparam int PFC_CW1_LSB    = 0;
  localparam int PFC_PLL_RUN_BIT = 2;
  localparam int PFC_BACKUP_BIT  = 3;
  localparam int PFC_PLL_CTL_W   = 4;
  localparam int PFC_IRQ_EN_W    = 2;

  // pad layout: four pins per port, ports b, c, d, serial 0, 1, 2
  localparam int PFC_PINS_PER_PORT = 4;
  localparam int PFC_NUM_PORTS     = 6;
  localparam int PFC_PAD_W         = 24;
  localparam int PFC_PORT_B        = 0;
  localparam int PFC_PORT_C        = 1;
  localparam int PFC_PORT_D        = 2;
  localparam int PFC_PORT_SER0     = 3;
  localparam int PFC_SER_CH        = 3;
  localparam int PFC_OD_CH         = 2;
  localparam int PFC_LT_W          = 4;
  localparam int PFC_SYNC_W        = 30;

  // reset values: all inputs, general purpose, pll stopped
  localparam logic [15:0] PFC_CFG_ONE_RST  = 16'h0000;
  localparam logic [15:0] PFC_CFG_TWO_RST  = 16'h0000;
  localparam logic [23:0] PFC_OUT_DATA_RST = 24'h000000;
  localparam logic [3:0]  PFC_PLL_CTL_RST  = 4'h0;
  localparam logic [1:0]  PFC_IRQ_EN_RST   = 2'h0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pfc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pfc_apb_rsp_type;

  typedef struct packed {
    logic [23:0] out;
    logic [23:0] oeN;
  } pfc_pad_type;

endpackage

// file: rtl/pfc_pin_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; the output moves only when stages two and three agree
module pfc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pfc_sync_type;

  pfc_sync_type st_r;
  pfc_sync_type st_nxt;

  // shift and filter
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule // pfc_pin_sync

// file: rtl/pfc_pump_drive.sv
`timescale 1ns/100ps
// three-state charge pump pin driver, registered
module pfc_pump_drive (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic divHigh,
  input  wire logic divLow,
  input  wire logic invert,
  output logic      pumpOut,
  output logic      pumpOeN
);

  typedef struct packed {
    logic out;
    logic oeN;
  } pfc_pump_type;

  pfc_pump_type st_r;
  pfc_pump_type st_nxt;

  // drive only on a mismatch, float on match or when disabled
  always_comb begin
    st_nxt.out = invert ? divLow : divHigh;
    st_nxt.oeN = !(enable && (divHigh != divLow));
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{out: 1'b0, oeN: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pumpOut = st_r.out;
  assign pumpOeN = st_r.oeN;

endmodule // pfc_pump_drive

// file: verification/pfc_port_pin_ctrl_chk.sv
`timescale 1ns/100ps
// watches pin drive, pump outputs and bus answers at the top ports
module pfc_port_pin_ctrl_chk
  import pfc_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire pfc_apb_req_type apbReq,
  input wire pfc_apb_rsp_type apbRsp,
  input wire pfc_pad_type     padDrv,
  input wire logic [1:0]      extIrqPin,
  input wire logic [2:0]      serSckIn,
  input wire logic [2:0]      serDataIn,
  input wire logic            pllDivHigh,
  input wire logic            pllDivLow,
  input wire logic            pll2DivHigh,
  input wire logic            pll2DivLow,
  input wire logic            mainPumpOutA,
  input wire logic            mainPumpOeNA,
  input wire logic            mainPumpOutB,
  input wire logic            mainPumpOeNB,
  input wire logic            secondPumpOut,
  input wire logic            secondPumpOeN,
  input wire logic            fmOscInEn,
  input wire logic            amOscInEn,
  input wire logic            pllRun,
  input wire logic            backupMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // main pumps follow the comparator one cycle later while the loop runs
  pump_high_a: assert property (
    (pllRun && !backupMode && pllDivHigh && !pllDivLow) ##1 (pllRun && !backupMode)
    |-> !mainPumpOeNA && mainPumpOutA && !mainPumpOeNB && mainPumpOutB)
    else $error("main pump not driven high");
  pump_low_a: assert property (
    (pllRun && !backupMode && pllDivLow && !pllDivHigh) ##1 (pllRun && !backupMode)
    |-> !mainPumpOeNA && !mainPumpOutA && !mainPumpOeNB && !mainPumpOutB)
    else $error("main pump not driven low");
  pump_float_a: assert property (
    (!pllRun || backupMode || pllDivHigh == pllDivLow) ##1 (!pllRun || backupMode
    || $past(pllDivHigh) == $past(pllDivLow)) |-> mainPumpOeNA && mainPumpOeNB)
    else $error("main pump driven while it should float");
  second_pump_inv_a: assert property (!secondPumpOeN |->
    secondPumpOut == $past(pll2DivLow) && $past(pll2DivHigh) != $past(pll2DivLow))
    else $error("second pump drive has wrong polarity");
  backup_float_a: assert property (backupMode [*2] |-> &padDrv.oeN)
    else $error("pad driven in backup");
  backup_zero_a: assert property (backupMode [*2] |->
    extIrqPin == 2'h0 && serSckIn == 3'h0 && serDataIn == 3'h0)
    else $error("pin level seen in backup");
  hv_open_drain_a: assert property ((padDrv.oeN[7:4] | ~padDrv.out[7:4]) == 4'hf)
    else $error("high voltage port driven high");
  osc_off_a: assert property ((!pllRun || backupMode) [*2] |-> !fmOscInEn && !amOscInEn)
    else $error("oscillator input enabled while stopped");
  reset_float_a: assert property ($rose(rstn) |->
    &padDrv.oeN && mainPumpOeNA && mainPumpOeNB)
    else $error("pin driven straight after reset");
  apb_ready_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("no ready in access cycle");
  // main scenarios
  cov_pump_high: cover property (!mainPumpOeNA && mainPumpOutA);
  cov_second: cover property (!secondPumpOeN);
  cov_backup: cover property (backupMode [*2]);
endmodule // pfc_port_pin_ctrl_chk

bind pfc_port_pin_ctrl pfc_port_pin_ctrl_chk u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .padDrv(padDrv),
  .extIrqPin(extIrqPin), .serSckIn(serSckIn), .serDataIn(serDataIn),
  .pllDivHigh(pllDivHigh), .pllDivLow(pllDivLow), .pll2DivHigh(pll2DivHigh),
  .pll2DivLow(pll2DivLow), .mainPumpOutA(mainPumpOutA), .mainPumpOeNA(mainPumpOeNA),
  .mainPumpOutB(mainPumpOutB), .mainPumpOeNB(mainPumpOeNB),
  .secondPumpOut(secondPumpOut), .secondPumpOeN(secondPumpOeN),
  .fmOscInEn(fmOscInEn), .amOscInEn(amOscInEn), .pllRun(pllRun), .backupMode(backupMode));

// file: verification/pfc_board_model.sv
`timescale 1ns/100ps
// board side of the pins: other drivers, pull-ups and undriven lines
module pfc_board_model
  import pfc_pkg::*;
(
  input  wire logic        clk,
  input  wire pfc_pad_type padDrv,
  input  wire logic [23:0] extVal,
  input  wire logic [23:0] extEn,
  input  wire logic        subOut,
  input  wire logic        subOeN,
  input  wire logic        extSub,
  input  wire logic        secOut,
  input  wire logic        secOeN,
  input  wire logic        extSec,
  output logic      [23:0] padIn,
  output logic             subIn,
  output logic             secIn
);
  localparam logic [23:0] PULL_UP = 24'h6000f0;
  logic tog = 1'b0;
  // an undriven line without pull-up changes every cycle
  always @(posedge clk) tog <= ~tog;
  // device drive wins, then the board's driver, then pull-up or wander
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      padIn[i] = !padDrv.oeN[i] ? padDrv.out[i] : extEn[i] ? extVal[i] : PULL_UP[i] | tog;
    end
  end
  assign subIn = !subOeN ? subOut : extSub;
  assign secIn = !secOeN ? secOut : extSec;
endmodule // pfc_board_model

// file: verification/pfc_port_pin_ctrl_test.sv
`timescale 1ns/100ps
// scenario bench for the port pin control block
module pfc_port_pin_ctrl_test
  import pfc_pkg::*;
;
  logic            ref_clk, rstn, ltPull, divH, divL, div2H, div2L, rerr;
  logic            oA, eA, oB, eB, subIn, subOut, subOeN, secIn, secOut, secOeN;
  logic            fmEn, amEn, mwlw, run, bkp, extSub, extSec;
  pfc_apb_req_type req;
  pfc_apb_rsp_type rsp;
  pfc_pad_type     padDrv;
  logic [23:0]     padIn, extVal, extEn;
  logic [3:0]      ltIn;
  logic [2:0]      sckOut, sckDrv, sdOut, sckIn, sdIn;
  logic [1:0]      irq;
  logic [31:0]     rdat;
  int              miscompares, compares, cyc;

  pfc_port_pin_ctrl u_pfc_port_pin_ctrl (.ref_clk(ref_clk), .rstn(rstn), .apbReq(req),
    .apbRsp(rsp), .padIn(padIn), .padDrv(padDrv), .lowThreshIn(ltIn), .lowThreshPullEn(ltPull),
    .serSckOut(sckOut), .serSckDrive(sckDrv), .serDataOut(sdOut), .serSckIn(sckIn),
    .serDataIn(sdIn), .extIrqPin(irq), .pllDivHigh(divH), .pllDivLow(divL),
    .pll2DivHigh(div2H), .pll2DivLow(div2L), .mainPumpOutA(oA), .mainPumpOeNA(eA),
    .mainPumpOutB(oB), .mainPumpOeNB(eB), .subPumpIn(subIn), .subPumpOut(subOut),
    .subPumpOeN(subOeN), .secondPumpIn(secIn), .secondPumpOut(secOut),
    .secondPumpOeN(secOeN), .fmOscInEn(fmEn), .amOscInEn(amEn), .amBandMwLw(mwlw),
    .pllRun(run), .backupMode(bkp));
  pfc_board_model u_pfc_board_model (.clk(ref_clk), .padDrv(padDrv), .extVal(extVal),
    .extEn(extEn), .subOut(subOut), .subOeN(subOeN), .extSub(extSub), .secOut(secOut),
    .secOeN(secOeN), .extSec(extSec), .padIn(padIn), .subIn(subIn), .secIn(secIn));

  task complete_run;
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // one bus transfer: setup, then access held until ready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task test_reset;
    apb(1'b0, PFC_CFG_ONE_OFS, 32'h0);
    chk(32'h0, rdat);
    apb(1'b0, PFC_CFG_TWO_OFS, 32'h0);
    chk(32'h0, rdat);
    chk(32'h00ffffff, {8'h0, padDrv.oeN});
    chk(32'h18, {27'h0, eA, eB, fmEn, amEn, run});
    $display("reset test done");
  endtask
  task test_pull;
    ltIn <= 4'h9;
    apb(1'b1, PFC_CFG_ONE_OFS, 32'h1);
    wt(6);
    chk(32'h1, {31'h0, ltPull});
    apb(1'b0, PFC_PIN_READ_OFS, 32'h0);
    chk(32'h9, {28'h0, rdat[27:24]});
    $display("pull-down test done");
  endtask
  task test_ports;
    extVal <= 24'h000502;
    extEn <= 24'h000f0a;
    apb(1'b1, PFC_CFG_TWO_OFS, 32'h02f5);
    apb(1'b1, PFC_OUT_DATA_OFS, 32'h3f);
    wt(6);
    chk(32'hd3a, {20'h0, padDrv.oeN[11:0]});
    chk(32'h5, {28'h0, padDrv.out[3:0] & 4'h5});
    apb(1'b0, PFC_PIN_READ_OFS, 32'h0);
    chk(32'h537, {20'h0, rdat[11:0]});
    $display("port direction test done");
  endtask
  task test_irq;
    apb(1'b1, PFC_CFG_TWO_OFS, 32'h0);
    extVal <= 24'h000302;
    wt(6);
    chk(32'h0, {30'h0, irq});
    apb(1'b1, PFC_IRQ_EN_OFS, 32'h1);
    wt(3);
    chk(32'h1, {30'h0, irq});
    apb(1'b1, PFC_IRQ_EN_OFS, 32'h2);
    wt(3);
    chk(32'h2, {30'h0, irq});
    $display("interrupt pin test done");
  endtask
  task test_serial;
    sckDrv <= 3'b100;
    sckOut <= 3'b100;
    sdOut <= 3'b100;
    extVal <= 24'h800000;
    extEn <= 24'h800000;
    apb(1'b1, PFC_CFG_ONE_OFS, 32'h1009);
    apb(1'b1, PFC_OUT_DATA_OFS, 32'h00100000);
    wt(6);
    chk(32'h8, {28'h0, padDrv.oeN[23:20]});
    chk(32'h7, {29'h0, padDrv.out[22:20]});
    chk(32'h4, {29'h0, sdIn & 3'b100});
    sckDrv <= 3'b000;
    extVal <= 24'ha00000;
    extEn <= 24'ha00000;
    wt(6);
    chk(32'h4, {29'h0, sckIn & 3'b100});
    sckDrv <= 3'b100;
    sdOut <= 3'b000;
    apb(1'b1, PFC_CFG_TWO_OFS, 32'h3000);
    wt(3);
    chk(32'ha, {28'h0, padDrv.oeN[23:20]});
    chk(32'h0, {31'h0, padDrv.out[22]});
    $display("serial pin test done");
  endtask
  task test_pump;
    extSub <= 1'b1;
    divH <= 1'b1;
    div2H <= 1'b1;
    apb(1'b1, PFC_PLL_CTL_OFS, 32'h6);
    wt(3);
    chk(32'h55, {24'h0, fmEn, amEn, mwlw, run, eA, oA, eB, oB});
    divH <= 1'b0;
    divL <= 1'b1;
    apb(1'b1, PFC_PLL_CTL_OFS, 32'h7);
    wt(3);
    chk(32'h70, {24'h0, fmEn, amEn, mwlw, run, eA, oA, eB, oB});
    divL <= 1'b0;
    apb(1'b1, PFC_PLL_CTL_OFS, 32'h4);
    wt(3);
    chk(32'h17, {27'h0, fmEn, amEn, run, eA, eB});
    divH <= 1'b1;
    apb(1'b1, PFC_CFG_TWO_OFS, 32'hc000);
    wt(3);
    chk(32'h4, {28'h0, subOeN, subOut, secOeN, secOut});
    div2H <= 1'b0;
    div2L <= 1'b1;
    wt(3);
    chk(32'h5, {28'h0, subOeN, subOut, secOeN, secOut});
    apb(1'b1, PFC_CFG_TWO_OFS, 32'h0);
    wt(6);
    apb(1'b0, PFC_PIN_READ_OFS, 32'h0);
    chk(32'h1, {30'h0, rdat[29:28]});
    $display("pump test done");
  endtask
  task test_backup;
    apb(1'b1, PFC_PLL_CTL_OFS, 32'hc);
    wt(4);
    chk(32'h00ffffff, {8'h0, padDrv.oeN});
    chk(32'h1c00, {19'h0, bkp, eA, eB, fmEn, amEn, irq, sckIn, sdIn});
    apb(1'b0, PFC_PIN_READ_OFS, 32'h0);
    chk(32'h0, rdat);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'h1, {31'h0, rerr});
    chk(32'h0, rdat);
    apb(1'b1, PFC_PLL_CTL_OFS, 32'h0);
    $display("backup test done");
  endtask

  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      complete_run;
    end
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    ltIn = 4'h0;
    {sckOut, sckDrv, sdOut} = 9'h0;
    {divH, divL, div2H, div2L, extSub, extSec} = 6'h0;
    extVal = 24'h0;
    extEn = 24'h0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    wt(4);
    test_reset;
    test_pull;
    test_ports;
    test_irq;
    test_serial;
    test_pump;
    test_backup;
    complete_run;
  end
endmodule // pfc_port_pin_ctrl_test
